// ==== shared/emp_pkg.sv ====
// Purpose: Shared constants, types and fault table of the emergency message producer
// Assumes: Object dictionary indices as seen by the SDO server
// Notes:   Payload byte 0 sits in data bits 7:0

package emp_pkg;

    // ------------------------------------------------------------
    // Object dictionary
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_ERR_CLASS = 16'h1001;
    localparam logic [15:0] IDX_HISTORY = 16'h1003;
    localparam logic [15:0] IDX_EMCY_ID = 16'h1014;
    localparam logic [7:0] SUB_ZERO = 8'h00;
    localparam int HIST_DEPTH = 5;
    localparam logic [7:0] HIST_DEPTH_B = 8'h05;

    // ------------------------------------------------------------
    // Identifier word fields
    // ------------------------------------------------------------
    localparam int ID_INVALID_BIT = 31;
    localparam int ID_RSVD_BIT = 30;
    localparam int ID_EXT_BIT = 29;
    localparam int ID_EXT_HI = 28;
    localparam int ID_EXT_LO = 11;
    localparam int ID_STD_HI = 10;
    localparam logic [3:0] EMCY_FUNC_CODE = 4'h1;
    localparam logic [31:0] ID_RESET = 32'h8000_0000;

    // ------------------------------------------------------------
    // Error class register
    // ------------------------------------------------------------
    localparam logic [7:0] ERR_CLASS_MASK = 8'h91;
    localparam logic [7:0] ERR_CLASS_RESET = 8'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        FLT_NO_ERROR,
        FLT_CAN_CTRL,
        FLT_NVM_ACCESS,
        FLT_SERIAL_ACCESS,
        FLT_RX_OVERRUN,
        FLT_TX_OVERRUN,
        FLT_CTRL_OVERRUN,
        FLT_GUARD_FAIL,
        FLT_BUSOFF_RECOVER,
        FLT_PDO_LENGTH,
        FLT_NODE_RESET
    } emp_fault_t;

    typedef struct packed {
        logic [15:0] code;
        logic [7:0] err_class;
        logic [7:0] mfr0;
    } emp_info_t;

    typedef struct packed {
        logic ext;
        logic [28:0] id;
        logic [63:0] data;
    } emp_frame_t;

    typedef struct packed {
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] wdata;
    } emp_od_req_t;

    // ------------------------------------------------------------
    // Fault table
    // ------------------------------------------------------------
    function automatic emp_info_t emp_fault_info(input emp_fault_t kind);
        emp_info_t r;
        r = '{code: 16'h0000, err_class: 8'h00, mfr0: 8'h00};
        case (kind)
            FLT_CAN_CTRL: r = '{16'h1000, 8'h81, 8'h01};
            FLT_NVM_ACCESS: r = '{16'h5000, 8'h81, 8'h02};
            FLT_SERIAL_ACCESS: r = '{16'h5000, 8'h81, 8'h03};
            FLT_RX_OVERRUN: r = '{16'h8110, 8'h11, 8'h04};
            FLT_TX_OVERRUN: r = '{16'h8110, 8'h11, 8'h05};
            FLT_CTRL_OVERRUN: r = '{16'h8110, 8'h11, 8'h06};
            FLT_GUARD_FAIL: r = '{16'h8130, 8'h11, 8'h07};
            FLT_BUSOFF_RECOVER: r = '{16'h8140, 8'h11, 8'h08};
            FLT_PDO_LENGTH: r = '{16'h8210, 8'h11, 8'h09};
            FLT_NODE_RESET: r = '{16'hff00, 8'h80, 8'h0a};
            default: r = '{16'h0000, 8'h00, 8'h00};
        endcase
        return r;
    endfunction : emp_fault_info

endpackage : emp_pkg

// ==== src/emp_history.sv ====
// Purpose: Five-deep emergency history, newest in entry 0
// Assumes: Push and clear never in the same cycle matter; push wins
// Notes:   Entry layout is code in 15:0, first maker byte in 23:16

`timescale 1ns/10ps

module emp_history (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control
    input wire logic push,
    input wire logic clear,
    input wire logic [31:0] din,
    // State
    output logic [emp_pkg::HIST_DEPTH-1:0][31:0] entries,
    output logic [7:0] count
);

    logic [emp_pkg::HIST_DEPTH-1:0][31:0] ent_ff;
    logic [7:0] cnt_ff;
    wire logic [7:0] nxt_cnt = (cnt_ff < emp_pkg::HIST_DEPTH_B) ? cnt_ff + 8'h01 : cnt_ff;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ent_ff <= '0;
            cnt_ff <= 8'h00;
        end else if (push) begin
            // Oldest entry falls off the end
            ent_ff <= {ent_ff[emp_pkg::HIST_DEPTH-2:0], din};
            cnt_ff <= nxt_cnt;
        end else if (clear) begin
            ent_ff <= '0;
            cnt_ff <= 8'h00;
        end
    end

    assign entries = ent_ff;
    assign count = cnt_ff;

    a_count_bounded: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cnt_ff <= emp_pkg::HIST_DEPTH_B) else $error("History count above five");

endmodule : emp_history

// ==== src/emp_producer.sv ====
// Purpose: Emergency frame producer with identifier word, error class and history
// Assumes: One fault accepted at a time; frame held until the CAN side takes it
// Notes:   Object dictionary port answers every access one cycle later
//
// Operation
// - Identifier word at 0x1014; bit 31 set means no frame is sent.
// - Bit 29 picks standard 11-bit or extended 29-bit identifier.
// - Bits 28-11 zero in standard form; bits 10-0 low identifier; bit 30 zero.
// - Default identifier is function code 0001 above the 7-bit node number.
// - Remote side may rewrite the identifier once the default is loaded; the write is taken whether or not bit 31 is set.
// - Each fault sends a frame while bit 31 is clear, then the event goes into history 0x1003.
// - History keeps at most five records.
// - Sub-entry 1 is newest, sub-entry 5 oldest.
// - Payload: code in bytes 0-1, class byte 2, maker field bytes 3-7.
// - Error code goes low byte first.
// - Only class bits 0, 4 and 7 may ever be set.
// - Class byte of each frame is shown as object error_class_register.
// - Error reset or no error sends an all-zero payload.
// - CAN controller fault: code 1000, class 81, maker 01.
// - Serial port fault: code 5000, class 81, maker 03.
// - Overruns: code 8110, class 11, maker 04, 05 or 06.
// - Guarding failure 8130 maker 07; bus-off recovery 8140 maker 08; class 11.
// - Process data length mismatch: code 8210, class 11, maker 09.
// - Node or communication reset request: code ff00, class 80, maker 0a.

`timescale 1ns/10ps

module emp_producer (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Node configuration
    input wire logic [6:0] node_id,
    // Fault reports
    input wire logic fault_valid,
    input wire emp_pkg::emp_fault_t fault_kind,
    output logic fault_ready,
    // Frame to the CAN controller
    output logic tx_valid,
    input wire logic tx_ready,
    output emp_pkg::emp_frame_t tx_frame,
    // Object dictionary access from the SDO server
    input wire logic od_rd,
    input wire logic od_wr,
    input wire emp_pkg::emp_od_req_t od_req,
    output logic od_ack,
    output logic od_err,
    output logic [31:0] od_rdata,
    // Status
    output logic [7:0] err_class
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SEND,
        ST_LOG
    } emp_state_t;

    emp_state_t state_ff;
    emp_state_t nxt_state;
    logic init_done_ff;
    logic [31:0] cobid_ff;
    logic [7:0] err_class_ff;
    emp_pkg::emp_frame_t tx_frame_ff;
    logic tx_valid_ff;
    logic fault_ready_ff;
    logic od_ack_ff;
    logic od_err_ff;
    logic [31:0] od_rdata_ff;
    logic [emp_pkg::HIST_DEPTH-1:0][31:0] hist_entries;
    logic [7:0] hist_count;

    // ------------------------------------------------------------
    // Fault intake and frame build
    // ------------------------------------------------------------
    wire emp_pkg::emp_info_t info = emp_pkg::emp_fault_info(fault_kind);
    wire logic fault_take = fault_valid && fault_ready_ff;
    wire logic id_valid = !cobid_ff[emp_pkg::ID_INVALID_BIT];
    wire logic id_ext = cobid_ff[emp_pkg::ID_EXT_BIT];
    wire logic [28:0] id_sel = id_ext ? cobid_ff[28:0] : {18'h00000, cobid_ff[10:0]};
    wire logic [63:0] payload = {32'h0000_0000, info.mfr0, info.err_class & emp_pkg::ERR_CLASS_MASK,
                                 info.code[15:8], info.code[7:0]};
    wire logic tx_done = tx_valid_ff && tx_ready;
    wire logic [31:0] hist_din = {8'h00, tx_frame_ff.data[31:24], tx_frame_ff.data[15:0]};
    wire logic hist_push = (state_ff == ST_LOG);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            // An invalid identifier drops the frame and the history record
            ST_IDLE: begin
                if (fault_take && id_valid) begin
                    nxt_state = ST_SEND;
                end
            end
            ST_SEND: begin
                if (tx_ready) begin
                    nxt_state = ST_LOG;
                end
            end
            ST_LOG: nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_frame_ff <= '0;
        end else if (fault_take) begin
            tx_frame_ff <= '{ext: id_ext, id: id_sel, data: payload};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_valid_ff <= 1'b0;
        end else if (fault_take && id_valid) begin
            tx_valid_ff <= 1'b1;
        end else if (tx_done) begin
            tx_valid_ff <= 1'b0;
        end
    end

    // Ready only in idle and only after the identifier is loaded
    wire logic nxt_fault_ready = init_done_ff && (nxt_state == ST_IDLE) && !fault_take;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_ready_ff <= 1'b0;
        end else begin
            fault_ready_ff <= nxt_fault_ready;
        end
    end

    // ------------------------------------------------------------
    // Error class object
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_class_ff <= emp_pkg::ERR_CLASS_RESET;
        end else if (hist_push) begin
            err_class_ff <= tx_frame_ff.data[23:16] & emp_pkg::ERR_CLASS_MASK;
        end
    end

    // ------------------------------------------------------------
    // Identifier word
    // ------------------------------------------------------------
    wire logic sel_id = (od_req.index == emp_pkg::IDX_EMCY_ID) && (od_req.sub == emp_pkg::SUB_ZERO);
    wire logic sel_class = (od_req.index == emp_pkg::IDX_ERR_CLASS)
                           && (od_req.sub == emp_pkg::SUB_ZERO);
    wire logic sel_hist = (od_req.index == emp_pkg::IDX_HISTORY)
                          && (od_req.sub <= emp_pkg::HIST_DEPTH_B);
    wire logic id_wr = od_wr && sel_id && init_done_ff;
    wire logic hist_clear = od_wr && sel_hist && (od_req.sub == emp_pkg::SUB_ZERO)
                            && (od_req.wdata == 32'h0000_0000);
    // Reserved bit forced low, upper bits cleared in standard form
    wire logic [31:0] id_wdata = {od_req.wdata[31], 1'b0, od_req.wdata[29],
                                  od_req.wdata[29] ? od_req.wdata[28:11] : 18'h00000,
                                  od_req.wdata[10:0]};
    wire logic [31:0] id_default = {21'h000000, emp_pkg::EMCY_FUNC_CODE, node_id};

    // Node number is a strap, so the default is caught after reset release
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cobid_ff <= emp_pkg::ID_RESET;
            init_done_ff <= 1'b0;
        end else if (!init_done_ff) begin
            cobid_ff <= id_default;
            init_done_ff <= 1'b1;
        end else if (id_wr) begin
            cobid_ff <= id_wdata;
        end
    end

    // ------------------------------------------------------------
    // Object dictionary answers
    // ------------------------------------------------------------
    wire logic [2:0] hist_slot = 3'(od_req.sub - 8'h01);
    wire logic [31:0] hist_word = (od_req.sub == emp_pkg::SUB_ZERO) ? {24'h000000, hist_count}
                                                                  : hist_entries[hist_slot];
    wire logic od_hit = sel_id || sel_class || sel_hist;
    // Error class is read only; history accepts only a zero write to sub 0
    wire logic od_bad = !od_hit || (od_wr && sel_class) || (od_wr && sel_hist && !hist_clear)
                        || (od_wr && sel_id && !init_done_ff);
    wire logic [31:0] od_mux = sel_id ? cobid_ff
                             : sel_class ? {24'h000000, err_class_ff}
                             : sel_hist ? hist_word
                             : 32'h0000_0000;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            od_ack_ff <= 1'b0;
            od_err_ff <= 1'b0;
            od_rdata_ff <= 32'h0000_0000;
        end else begin
            od_ack_ff <= od_rd || od_wr;
            od_err_ff <= (od_rd || od_wr) && od_bad;
            od_rdata_ff <= (od_rd && !od_bad) ? od_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // History
    // ------------------------------------------------------------
    emp_history u_emp_history (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .push(hist_push),
        .clear(hist_clear),
        .din(hist_din),
        .entries(hist_entries),
        .count(hist_count)
    );

    assign fault_ready = fault_ready_ff;
    assign tx_valid = tx_valid_ff;
    assign tx_frame = tx_frame_ff;
    assign od_ack = od_ack_ff;
    assign od_err = od_err_ff;
    assign od_rdata = od_rdata_ff;
    assign err_class = err_class_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_no_send_invalid: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(tx_valid_ff) |-> !$past(cobid_ff[31])) else $error("Frame sent while disabled");

    a_std_id_form: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tx_valid_ff && !tx_frame_ff.ext) |-> (tx_frame_ff.id[28:11] == 18'h00000))
        else $error("Standard identifier has upper bits");

    a_id_word_form: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !cobid_ff[30] && (cobid_ff[29] || cobid_ff[28:11] == 18'h00000))
        else $error("Identifier word malformed");

    a_default_id: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(init_done_ff) |-> (cobid_ff == {21'h000000, 4'h1, $past(node_id)}))
        else $error("Default identifier wrong");

    a_id_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        id_wr |=> (cobid_ff[10:0] == $past(od_req.wdata[10:0]))
                  && (cobid_ff[31] == $past(od_req.wdata[31])))
        else $error("Identifier write lost");

    a_log_after_send: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tx_done |=> hist_push ##1 !hist_push) else $error("History not logged after send");

    a_newest_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
        hist_push |=> (hist_entries[0] == $past(hist_din))) else $error("Newest entry wrong");

    a_shift_older: assert property (@(posedge sys_clk) disable iff (!rst_n)
        hist_push |=> (hist_entries[4] == $past(hist_entries[3]))
                      && (hist_entries[1] == $past(hist_entries[0])))
        else $error("History did not shift");

    a_code_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fault_take |=> (tx_frame_ff.data[7:0] == $past(info.code[7:0]))
                       && (tx_frame_ff.data[15:8] == $past(info.code[15:8])))
        else $error("Error code byte order wrong");

    a_class_mask: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ((err_class_ff & 8'h6e) == 8'h00) && ((tx_frame_ff.data[23:16] & 8'h6e) == 8'h00))
        else $error("Unsupported class bit set");

    a_class_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
        hist_push |=> (err_class_ff == $past(tx_frame_ff.data[23:16])))
        else $error("Class object not updated");

    a_reset_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (fault_take && fault_kind == emp_pkg::FLT_NO_ERROR) |=> (tx_frame_ff.data == 64'h0))
        else $error("Reset frame not zero");

    a_pdo_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (fault_take && fault_kind == emp_pkg::FLT_PDO_LENGTH)
        |=> (tx_frame_ff.data == 64'h0000_0000_0911_8210)) else $error("Length fault frame wrong");

    a_frame_held: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tx_valid_ff && !tx_ready) |=> tx_valid_ff && $stable(tx_frame_ff))
        else $error("Frame dropped before taken");

    a_busy_refuse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fault_take |=> !fault_ready_ff) else $error("Fault port ready right after take");

    a_invalid_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (fault_take && !id_valid) |=> !tx_valid_ff && !hist_push)
        else $error("Frame raised while identifier invalid");

endmodule : emp_producer

// ==== tb/emp_master_model.sv ====
// Purpose: CAN side partner that takes emergency frames from the producer
// Assumes: A frame is taken once it has waited the requested stall
// Notes:   Stall 0 takes a frame in the cycle it appears

`timescale 1ns/10ps

module emp_master_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Frame handshake
    input wire logic tx_valid,
    input wire logic [1:0] stall,
    output logic tx_ready
);
    logic [1:0] wait_ff;
    logic [1:0] nxt_wait;

    // Ready only with a frame present; counter clears on take, which comes by 3, so no wrap
    assign tx_ready = tx_valid && (wait_ff >= stall);
    assign nxt_wait = (tx_ready || !tx_valid) ? 2'h0 : wait_ff + 2'h1;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_ff <= 2'h0;
        end else begin
            wait_ff <= nxt_wait;
        end
    end
endmodule : emp_master_model

// ==== tb/emp_producer_bench.sv ====
// Purpose: Self-checking bench of the emergency message producer
// Assumes: Inputs change on the falling edge; outputs are read there too
// Notes:   Drivers queue expected frames and answers; a watcher pops them

`timescale 1ns/10ps

module emp_producer_bench;
    // ------------------------------------------------------------
    // Signals and tables
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [6:0] node_id;
    logic fault_valid = 1'b0;
    emp_pkg::emp_fault_t fault_kind = emp_pkg::FLT_NO_ERROR;
    logic fault_ready, tx_valid, tx_ready, od_ack, od_err;
    emp_pkg::emp_frame_t tx_frame;
    logic od_rd = 1'b0;
    logic od_wr = 1'b0;
    emp_pkg::emp_od_req_t od_req = '0;
    logic [31:0] od_rdata, id_word;
    logic [7:0] err_class, exp_class;
    logic [1:0] stall = 2'h0;
    logic [31:0] lfsr = 32'h52c3;
    logic [95:0] frame_q[$];
    logic [32:0] od_q[$];
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [15:0] code_t [11] = '{16'h0000, 16'h1000, 16'h5000, 16'h5000, 16'h8110,
        16'h8110, 16'h8110, 16'h8130, 16'h8140, 16'h8210, 16'hff00};
    logic [7:0] class_t [11] = '{8'h00, 8'h81, 8'h81, 8'h81, 8'h11, 8'h11,
        8'h11, 8'h11, 8'h11, 8'h11, 8'h80};

    emp_producer u_emp_producer (
        .sys_clk(sys_clk), .rst_n(rst_n), .node_id(node_id),
        .fault_valid(fault_valid), .fault_kind(fault_kind), .fault_ready(fault_ready),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_frame(tx_frame),
        .od_rd(od_rd), .od_wr(od_wr), .od_req(od_req), .od_ack(od_ack),
        .od_err(od_err), .od_rdata(od_rdata), .err_class(err_class)
    );

    emp_master_model u_emp_master_model (
        .sys_clk(sys_clk), .rst_n(rst_n), .tx_valid(tx_valid), .stall(stall),
        .tx_ready(tx_ready)
    );

    always #10 sys_clk = ~sys_clk;

    function automatic logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : next_rand

    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        // A result still owed at the end means the design went quiet
        check(96'(frame_q.size()), 96'h0);
        check(96'(od_q.size()), 96'h0);
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    // Entered and left at a falling edge; request held for one cycle
    task automatic od_acc(input logic w, input logic [15:0] i, input logic [7:0] s,
                          input logic [31:0] d, input logic e, input logic [31:0] r);
        od_q.push_back({e, r});
        od_rd = !w;
        od_wr = w;
        od_req = '{index: i, sub: s, wdata: d};
        @(negedge sys_clk);
    endtask : od_acc

    task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic e,
                      input logic [31:0] r);
        od_acc(1'b0, i, s, 32'h0, e, r);
    endtask : rd

    // Reads and writes are left standing for back to back use; od_idle ends a burst
    task automatic od_idle;
        od_rd = 1'b0;
        od_wr = 1'b0;
        @(negedge sys_clk);
    endtask : od_idle

    task automatic raise(input int k);
        emp_pkg::emp_frame_t f;
        while (fault_ready !== 1'b1) @(negedge sys_clk);
        lfsr = next_rand(lfsr);
        stall = lfsr[1:0];
        fault_kind = emp_pkg::emp_fault_t'(k);
        fault_valid = 1'b1;
        f.ext = id_word[29];
        f.id = id_word[29] ? id_word[28:0] : {18'h0, id_word[10:0]};
        f.data = {32'h0, 8'(k), class_t[k], code_t[k]};
        if (!id_word[31]) begin
            frame_q.push_back({2'b0, f});
            exp_class = class_t[k];
        end
        @(negedge sys_clk);
        fault_valid = 1'b0;
        check({95'h0, fault_ready}, 96'h0);
        while (fault_ready !== 1'b1) @(negedge sys_clk);
        check({88'h0, err_class}, {88'h0, exp_class});
    endtask : raise

    // ------------------------------------------------------------
    // Watcher and timeout
    // ------------------------------------------------------------
    always @(negedge sys_clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (frame_q.size() == 0) begin
                check({2'b0, tx_frame}, 'x);
            end else begin
                check({2'b0, tx_frame}, frame_q.pop_front());
            end
        end
        if (od_ack === 1'b1) begin
            if (od_q.size() == 0) begin
                check({63'h0, od_err, od_rdata}, 'x);
            end else begin
                check({63'h0, od_err, od_rdata}, {63'h0, od_q.pop_front()});
            end
        end
    end

    // Whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        lfsr = next_rand(lfsr);
        node_id = lfsr[6:0];
        id_word = {24'h0, 1'b1, lfsr[6:0]};
        exp_class = 8'h00;
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        // Identifier write at the first edge is refused: default not yet loaded
        od_acc(1'b1, 16'h1014, 8'h00, 32'h0000_0123, 1'b1, 32'h0);
        od_idle();
        check({88'h0, err_class}, 96'h0);
        rd(16'h1014, 8'h00, 1'b0, id_word);
        rd(16'h1001, 8'h00, 1'b0, 32'h0);
        rd(16'h1003, 8'h00, 1'b0, 32'h0);
        od_idle();
        for (int k = 0; k < 11; k++) begin
            raise(k);
        end
        rd(16'h1003, 8'h00, 1'b0, 32'h5);
        for (int s = 1; s <= 5; s++) begin
            rd(16'h1003, 8'(s), 1'b0, {8'h00, 8'(11 - s), code_t[11 - s]});
        end
        rd(16'h1001, 8'h00, 1'b0, 32'h80);
        rd(16'h1003, 8'h06, 1'b1, 32'h0);
        od_acc(1'b1, 16'h1001, 8'h00, 32'h11, 1'b1, 32'h0);
        od_acc(1'b1, 16'h1003, 8'h00, 32'h1, 1'b1, 32'h0);
        rd(16'h2000, 8'h00, 1'b1, 32'h0);
        od_acc(1'b1, 16'h1014, 8'h00, 32'h6abc_def5, 1'b0, 32'h0);
        id_word = 32'h2abc_def5;
        rd(16'h1014, 8'h00, 1'b0, id_word);
        od_idle();
        raise(5);
        od_acc(1'b1, 16'h1014, 8'h00, 32'h4001_2345, 1'b0, 32'h0);
        id_word = 32'h0000_0345;
        rd(16'h1014, 8'h00, 1'b0, id_word);
        od_idle();
        raise(9);
        od_acc(1'b1, 16'h1014, 8'h00, 32'h8000_0081, 1'b0, 32'h0);
        id_word = 32'h8000_0081;
        od_idle();
        raise(1);
        rd(16'h1003, 8'h01, 1'b0, {8'h00, 8'h09, code_t[9]});
        od_acc(1'b1, 16'h1003, 8'h00, 32'h0, 1'b0, 32'h0);
        rd(16'h1003, 8'h00, 1'b0, 32'h0);
        od_idle();
        repeat (3) @(negedge sys_clk);
        final_report();
    end
endmodule : emp_producer_bench
